// >>> shared/irm_cfg.svh
// Register offsets, field positions, reset values and timing counts of the infrared mode setup block.
// Assumes inclusion by bare name; definitions only.
`ifndef IRM_CFG_SVH
`define IRM_CFG_SVH
// ----------------------------------------------------------------------------
// Byte offsets on the register bus.
// ----------------------------------------------------------------------------
`define IRM_OFS_RING_START   8'h00
`define IRM_OFS_RING_BASE_L 8'h04
`define IRM_OFS_RING_BASE_H 8'h08
`define IRM_OFS_RING_SIZE   8'h0c
`define IRM_OFS_PRI_CFG     8'h10
`define IRM_OFS_SEC_CFG     8'h14
`define IRM_OFS_MAX_PKT     8'h18
`define IRM_OFS_PHY_CFG     8'h1c
`define IRM_OFS_ENABLE      8'h20
`define IRM_OFS_INTF_CFG    8'h24
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define IRM_ENA_BIT         15
`define IRM_INTF_HALF_BIT   3
`define IRM_INTF_CLKEN_BIT  2
`define IRM_PRI_TE_BIT      12
`define IRM_PRI_RE_BIT      11
`define IRM_PRI_ME_BIT      10
`define IRM_PRI_RA_BIT      9
`define IRM_PRI_FIR_BIT     6
`define IRM_PRI_MIR_BIT     5
`define IRM_PRI_SIR_BIT     4
`define IRM_PRI_TI_BIT      1
`define IRM_PRI_RI_BIT      0
`define IRM_PHY_BAUD_LSB    10
`define IRM_PHY_PW_LSB      5
`define IRM_PHY_PRE_LSB     0
`define IRM_RING_ALIGN_BITS 10
// ----------------------------------------------------------------------------
// Reset values and status words.
// ----------------------------------------------------------------------------
`define IRM_RST_INTF_CFG    16'h0003
`define IRM_RST_MAX_PKT     16'h0020
`define IRM_STAT_FIR        16'hc7ff
`define IRM_STAT_SLOW       16'ha7ff
`define IRM_BIT_TIME_PS     1000
`endif

// >>> shared/irm_pkg.sv
// Types of the infrared mode setup block.
// Assumes nothing beyond a SystemVerilog compiler.
package irm_pkg;
  typedef enum logic [1:0] {
    IRM_IDLE    = 2'b00,
    IRM_ENABLED = 2'b01,
    IRM_RUNNING = 2'b10
  } irm_state_t;
  typedef enum logic [1:0] {
    IRM_MODE_SIR = 2'b00,
    IRM_MODE_MIR = 2'b01,
    IRM_MODE_FIR = 2'b10
  } irm_mode_t;
endpackage : irm_pkg

// >>> src/irm_tick.sv
// Rate tick generator: one pulse per infrared bit period or half-clocked.
// Assumes the main block supplies a stable divisor while running.
module irm_tick
  import irm_pkg::*;
(
  input  wire logic        clk,      // Bus clock.
  input  wire logic        rst_n,    // Asynchronous reset, active low.
  input  wire logic        run,      // Counting allowed.
  input  wire logic        half,     // Advance every second clock only.
  input  wire logic [15:0] divisor,  // Cycles per tick minus one.
  output logic             tick      // One-cycle pulse.
);
  typedef struct packed {
    logic        ph;
    logic [15:0] cnt;
    logic        tick;
  } irm_tick_st_t;
  irm_tick_st_t s_q, s_d;
  // Counts down; in half-clock mode only every other cycle advances.
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    s_d.ph   = ~s_q.ph;
    if (!run) begin
      s_d.cnt = divisor;
      s_d.ph  = 1'b0;
    end else if (!half || s_q.ph) begin
      if (s_q.cnt == 16'h0000) begin
        s_d.cnt  = divisor;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
  end
  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule : irm_tick

// >>> src/irm_setup.sv
// Register file and mode control of the infrared link setup block.
// Assumes an Avalon-MM master on REF_CLK and a transceiver outside the pins.
// Assumes software disables the block before it changes any setting.
`include "irm_cfg.svh"

// Overview of operation
// - Half-clock control makes link logic advance at half bus rate.
// - Rates 2400 bps to 4 Mbps through slow, medium and fast modes.
// - Slow mode baud field 47..0 selects rate; pulse width 12, medium 8.
// - Preamble field holds preamble bytes minus one; fast uses 15.
// - Configuration writes other than the enable, interface and ring trigger words only take effect while enable is clear.
// - Maximum packet length register bounds packet bytes, 0x0020 is 32.
// - Primary word enables the transmitter and selects mode; its receiver and scheduler enable bits are stored but act on nothing.
// - Transmit and receive pin polarity inversion controls exist.
// - Secondary word 0x0004 selects a 48 MHz phy clock.
// - Writing 0x8000 enables; status reads 0xC7FF fast, 0xA7FF otherwise.
// - Writing zero to the ring trigger starts ring processing.
// - Speed select output high in fast or medium, low in slow.
module irm_setup
  import irm_pkg::*;
#(
  parameter int ADDR_W = 8  // Byte address width.
) (
  input  wire logic              REF_CLK,        // Bus clock, 200 MHz.
  input  wire logic              NRST,           // Asynchronous reset, active low.
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,    // Byte address.
  input  wire logic              AVS_READ,       // Read request.
  input  wire logic              AVS_WRITE,      // Write request.
  input  wire logic [31:0]       AVS_WRITEDATA,  // Write data.
  input  wire logic [3:0]        AVS_BYTEENABLE, // Byte lanes.
  output logic [31:0]            AVS_READDATA,   // Read data.
  output logic                   AVS_WAITREQUEST, // Stall until answer.
  output logic [1:0]             AVS_RESPONSE,   // 00 ok, 10 slave error.
  input  wire logic              IR_RXD,         // Serial input from transceiver.
  output logic                   IR_TXD,         // Serial output to transceiver.
  output logic                   SPEED_SELECT_OUTPUT, // High for fast or medium.
  output logic                   RING_ACTIVE,    // Ring fetching running.
  output logic [31:0]            RING_BASE,      // Aligned ring base.
  output logic [1:0]             PHY_CLK_SEL,    // Phy clock speed code.
  output logic                   LINK_CLK_EN     // Clock gate to link logic.
);
  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  // Every flip-flop of the block outside the tick counter lives in this one record, so reset and
  // the next-state copy can never fall out of step.
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [15:0] intf_cfg;
    logic [15:0] enable;
    logic [15:0] max_pkt;
    logic [15:0] phy_cfg;
    logic [15:0] pri_cfg;
    logic [15:0] sec_cfg;
    logic [15:0] base_lo;
    logic [15:0] base_hi;
    logic [15:0] ring_size;
    irm_state_t  st;
    logic        rx_s1;
    logic        rx_s2;
    logic        txd;
    logic        spd;
    logic        clk_en;
    logic        wreq;
    logic        ring;
  } irm_st_t;
  irm_st_t s_q, s_d;

  // Rate tick, registered in the tick counter, and write-decode helpers, which are combinational.
  logic        tick;
  logic [15:0] divisor;
  logic [15:0] wv;
  logic        wr_ok;
  logic        cfg_ok;

  // Applies byte enables of the low half to a 16-bit register.
  // Only lanes 0 and 1 exist; the upper half of the bus is ignored.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16
  // Current mode from the primary word; fast wins over medium over slow.
  function automatic irm_mode_t mode_of(input logic [15:0] pri);
    if (pri[`IRM_PRI_FIR_BIT]) return IRM_MODE_FIR;
    else if (pri[`IRM_PRI_MIR_BIT]) return IRM_MODE_MIR;
    else return IRM_MODE_SIR;
  endfunction : mode_of

  // Status word shown by the enable register while the block is on.
  function automatic logic [15:0] status_word(input logic [15:0] pri);
    if (mode_of(pri) == IRM_MODE_FIR) return `IRM_STAT_FIR;
    else return `IRM_STAT_SLOW;
  endfunction : status_word

  // True for a word-aligned offset inside the register map.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a <= `IRM_OFS_INTF_CFG) && (a[1:0] == 2'b00);
  endfunction : is_mapped

  // --------------------------------------------------------------------------
  // Rate divisor.
  // --------------------------------------------------------------------------
  // Slow mode uses the baud field as the divisor; medium and fast tick every cycle, or every second cycle when half-clocked.
  // Half-clock operation is applied in the tick counter, so the field keeps
  // the same meaning whatever the bus rate.
  always_comb begin
    if (mode_of(s_q.pri_cfg) == IRM_MODE_SIR) begin
      divisor = {10'h000, s_q.phy_cfg[`IRM_PHY_BAUD_LSB +: 6]};
    end else begin
      divisor = 16'h0000;
    end
  end

  // The divider runs only while the clock gate is open and the ring is running.
  irm_tick u_tick (
    .clk     (REF_CLK),
    .rst_n   (NRST),
    .run     (s_q.clk_en && s_q.st == IRM_RUNNING),
    .half    (s_q.intf_cfg[`IRM_INTF_HALF_BIT]),
    .divisor (divisor),
    .tick    (tick)
  );

  // --------------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------------
  // Bus slave answers one cycle after the request with waitrequest low.
  always_comb begin
    s_d       = s_q;
    wv        = merge16(16'h0000, AVS_WRITEDATA, AVS_BYTEENABLE);
    wr_ok     = AVS_WRITE && !s_q.ack;
    cfg_ok    = !s_q.enable[`IRM_ENA_BIT];
    // ------------------------------------------------------------------------
    // Bus handshake and pin synchroniser.
    // ------------------------------------------------------------------------
    // The ack flop falls again after each answer, so a request still held high
    // at the completing edge is never taken a second time.
    s_d.ack   = (AVS_READ || AVS_WRITE) && !s_q.ack;
    s_d.wreq  = !s_d.ack;
    // Two flops bring the asynchronous receive pin into the bus clock domain.
    s_d.rx_s1 = IR_RXD;
    s_d.rx_s2 = s_q.rx_s1;
    // The link clock gate follows the interface register one cycle late.
    s_d.clk_en = s_q.intf_cfg[`IRM_INTF_CLKEN_BIT];
    s_d.resp  = 2'b00;
    s_d.rdata = 32'h0000_0000;

    // ------------------------------------------------------------------------
    // Register reads.
    // ------------------------------------------------------------------------
    // Read data is registered and stands only in the cycle of the answer.
    if (AVS_READ && !s_q.ack) begin
      if (AVS_ADDRESS == `IRM_OFS_ENABLE) begin
        if (s_q.enable[`IRM_ENA_BIT]) begin
          s_d.rdata = {16'h0000, status_word(s_q.pri_cfg)};
        end else begin
          s_d.rdata = {16'h0000, s_q.enable};
        end
      end else if (AVS_ADDRESS == `IRM_OFS_INTF_CFG) begin
        s_d.rdata = {16'h0000, s_q.intf_cfg};
      end else if (AVS_ADDRESS == `IRM_OFS_MAX_PKT) begin
        s_d.rdata = {16'h0000, s_q.max_pkt};
      end else if (AVS_ADDRESS == `IRM_OFS_PHY_CFG) begin
        s_d.rdata = {16'h0000, s_q.phy_cfg};
      end else if (AVS_ADDRESS == `IRM_OFS_PRI_CFG) begin
        s_d.rdata = {16'h0000, s_q.pri_cfg};
      end else if (AVS_ADDRESS == `IRM_OFS_SEC_CFG) begin
        s_d.rdata = {16'h0000, s_q.sec_cfg};
      end else if (AVS_ADDRESS == `IRM_OFS_RING_BASE_L) begin
        // The low ten bits read back as zero whatever was written.
        s_d.rdata = {16'h0000, s_q.base_lo[15:`IRM_RING_ALIGN_BITS], 10'h000};
      end else if (AVS_ADDRESS == `IRM_OFS_RING_BASE_H) begin
        s_d.rdata = {16'h0000, s_q.base_hi};
      end else if (AVS_ADDRESS == `IRM_OFS_RING_SIZE) begin
        s_d.rdata = {16'h0000, s_q.ring_size};
      end else if (AVS_ADDRESS == `IRM_OFS_RING_START) begin
        s_d.rdata = {30'h0000_0000, s_q.st};
      end else begin
        s_d.resp = 2'b10;
      end
    end

    // ------------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------------
    // Settings other than the enable and interface words only change while disabled. A locked setting answers ok but keeps
    // its value, so a driver that forgets to disable sees an unchanged read-back.
    if (wr_ok) begin
      if (AVS_ADDRESS == `IRM_OFS_ENABLE) begin
        s_d.enable = merge16(s_q.enable, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_INTF_CFG) begin
        s_d.intf_cfg = merge16(s_q.intf_cfg, AVS_WRITEDATA, AVS_BYTEENABLE) & 16'h000f;
      end else if (AVS_ADDRESS == `IRM_OFS_RING_START) begin
        // Only a zero written while enabled starts the ring; anything else is dropped.
        if (s_q.st == IRM_ENABLED && wv == 16'h0000) begin
          s_d.st = IRM_RUNNING;
        end
      end else if (!cfg_ok) begin
        s_d.resp = 2'b00;
      end else if (AVS_ADDRESS == `IRM_OFS_MAX_PKT) begin
        s_d.max_pkt = merge16(s_q.max_pkt, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_PHY_CFG) begin
        s_d.phy_cfg = merge16(s_q.phy_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_PRI_CFG) begin
        s_d.pri_cfg = merge16(s_q.pri_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_SEC_CFG) begin
        s_d.sec_cfg = merge16(s_q.sec_cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_RING_BASE_L) begin
        s_d.base_lo = merge16(s_q.base_lo, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_RING_BASE_H) begin
        s_d.base_hi = merge16(s_q.base_hi, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else if (AVS_ADDRESS == `IRM_OFS_RING_SIZE) begin
        s_d.ring_size = merge16(s_q.ring_size, AVS_WRITEDATA, AVS_BYTEENABLE);
      end else begin
        s_d.resp = 2'b10;
      end
    end
    // Writes outside the map or off a word boundary answer with a slave error.
    if (wr_ok && !is_mapped(AVS_ADDRESS)) begin
      s_d.resp = 2'b10;
    end

    // ------------------------------------------------------------------------
    // Enable sequencing.
    // ------------------------------------------------------------------------
    // Idle until enabled, then wait for the trigger. Clearing the enable bit
    // drops a running ring back to idle at once.
    case (s_q.st)
      IRM_IDLE: begin
        if (s_q.enable[`IRM_ENA_BIT]) s_d.st = IRM_ENABLED;
      end
      IRM_ENABLED: begin
        if (!s_q.enable[`IRM_ENA_BIT]) s_d.st = IRM_IDLE;
      end
      IRM_RUNNING: begin
        if (!s_q.enable[`IRM_ENA_BIT]) s_d.st = IRM_IDLE;
      end
      default: begin
        s_d.st = IRM_IDLE;
      end
    endcase
    // A registered copy of the running state drives the ring output directly.
    s_d.ring = (s_d.st == IRM_RUNNING);

    // ------------------------------------------------------------------------
    // Serial line and speed pin.
    // ------------------------------------------------------------------------
    // Loop-back idle line: transmitter echoes nothing but idle, inverted as asked.
    // The received line is synchronised but not decoded, so it is masked here.
    if (tick && s_q.pri_cfg[`IRM_PRI_TE_BIT]) begin
      s_d.txd = s_q.pri_cfg[`IRM_PRI_TI_BIT] ^ ((s_q.rx_s2 ^ s_q.pri_cfg[`IRM_PRI_RI_BIT])
                & s_q.pri_cfg[`IRM_PRI_RE_BIT] & 1'b0);
    end else if (s_q.st != IRM_RUNNING) begin
      s_d.txd = s_q.pri_cfg[`IRM_PRI_TI_BIT];
    end
    // The speed pin is high in fast and medium mode.
    s_d.spd = mode_of(s_q.pri_cfg) != IRM_MODE_SIR;
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------
  // Reset holds waitrequest high and loads the interface and packet defaults.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q          <= '0;
      s_q.wreq     <= 1'b1;
      s_q.intf_cfg <= `IRM_RST_INTF_CFG;
      s_q.max_pkt  <= `IRM_RST_MAX_PKT;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all from flip-flops.
  // --------------------------------------------------------------------------
  // Plain wires from the state record; no gate sits between a flop and a pin.
  assign AVS_READDATA        = s_q.rdata;
  assign AVS_WAITREQUEST     = s_q.wreq;
  assign AVS_RESPONSE        = s_q.resp;
  assign IR_TXD              = s_q.txd;
  assign SPEED_SELECT_OUTPUT = s_q.spd;
  assign RING_ACTIVE         = s_q.ring;
  assign RING_BASE           = {s_q.base_hi, s_q.base_lo[15:`IRM_RING_ALIGN_BITS], 10'h000};
  assign PHY_CLK_SEL         = s_q.sec_cfg[3:2];
  assign LINK_CLK_EN         = s_q.clk_en;
endmodule : irm_setup

// >>> sim/irm_setup_monitor.sv
// Concurrent checks on the ports of the infrared setup block.
// Assumes one REF_CLK domain and an asynchronous active-low NRST.
`include "irm_cfg.svh"
module irm_setup_mon #(
  parameter int ADDR_W = 8  // Byte address width.
) (
  input wire logic              REF_CLK,             // Bus clock.
  input wire logic              NRST,                // Reset, active low.
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,         // Byte address.
  input wire logic              AVS_READ,            // Read request.
  input wire logic              AVS_WRITE,           // Write request.
  input wire logic [31:0]       AVS_WRITEDATA,       // Write data.
  input wire logic [31:0]       AVS_READDATA,        // Read data.
  input wire logic              AVS_WAITREQUEST,     // Stall.
  input wire logic [1:0]        AVS_RESPONSE,        // Response code.
  input wire logic              SPEED_SELECT_OUTPUT, // Speed pin.
  input wire logic              RING_ACTIVE,         // Ring running.
  input wire logic [31:0]       RING_BASE,           // Ring base.
  input wire logic [1:0]        PHY_CLK_SEL,         // Phy clock code.
  input wire logic              LINK_CLK_EN          // Link clock gate.
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // Completed writes by target.
  // --------------------------------------------------------------------------
  // Decodes the answer cycle of a write, one edge after the write takes effect.
  logic req, done_w, trig, sec, pri, intf;
  assign req    = AVS_READ || AVS_WRITE;
  assign done_w = AVS_WRITE && !AVS_WAITREQUEST;
  assign trig   = done_w && AVS_ADDRESS == `IRM_OFS_RING_START && AVS_WRITEDATA[15:0] == 16'h0000;
  assign sec    = done_w && AVS_ADDRESS == `IRM_OFS_SEC_CFG;
  assign pri    = done_w && AVS_ADDRESS == `IRM_OFS_PRI_CFG;
  assign intf   = done_w && AVS_ADDRESS == `IRM_OFS_INTF_CFG;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  a_wait_one_cycle: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("late answer");
  a_wait_short_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
  a_resp_unmapped: assert property (req && AVS_WAITREQUEST && AVS_ADDRESS > 8'h24 |=> AVS_RESPONSE == 2'b10)
    else $error("no error response");
  a_resp_mapped: assert property (req && AVS_WAITREQUEST && AVS_ADDRESS[1:0] == 2'b00 && AVS_ADDRESS <= 8'h24
    |=> AVS_RESPONSE == 2'b00) else $error("bad ok response");
  a_read_upper_zero: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
    else $error("upper half set");
  a_base_aligned: assert property (RING_BASE[9:0] == 10'h000) else $error("ring base unaligned");
  a_ring_start_cause: assert property ($rose(RING_ACTIVE) |-> trig || $past(trig, 1) || $past(trig, 2))
    else $error("ring started without trigger");
  a_phy_sel_cause: assert property ($changed(PHY_CLK_SEL) |-> sec || $past(sec, 1))
    else $error("phy clock code moved");
  a_speed_cause: assert property ($changed(SPEED_SELECT_OUTPUT) |-> $past(pri, 1) || $past(pri, 2))
    else $error("speed pin moved");
  a_clk_gate_cause: assert property ($changed(LINK_CLK_EN) |-> $past(intf, 1) || $past(intf, 2) || $past(intf, 3))
    else $error("clock gate moved");
endmodule : irm_setup_mon
bind irm_setup irm_setup_mon #(.ADDR_W(ADDR_W)) u_mon (.REF_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE, .SPEED_SELECT_OUTPUT, .RING_ACTIVE,
  .RING_BASE, .PHY_CLK_SEL, .LINK_CLK_EN);

// >>> sim/irm_xcvr_model.sv
// Behavioural infrared transceiver facing the serial pins.
// Assumes the bus clock as its sampling clock.
module irm_xcvr_model (
  input wire logic clk,   // Sampling clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic txd,   // Light out request.
  output logic     rxd    // Detected light.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Echoes the own emitter one clock late, so pin polarity shows on both pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rxd <= 1'b0;
    else rxd <= txd;
  end
endmodule : irm_xcvr_model

// >>> sim/tb_top.sv
// Register-level bench of the infrared setup block over Avalon-MM.
// Assumes the block and the transceiver model are compiled before it.
`include "irm_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, nrst, avs_rd, avs_wr, wait_r, txd, rxd, spd, ring_act, clk_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, ring_base, q;
  logic [3:0] be;
  logic [1:0] resp, phy_sel, r;
  int n_errors, comparisons, m;
  localparam logic [15:0] phy_t [3] = '{16'h000f, 16'h0101, 16'h0180};
  localparam logic [15:0] pri_t [3] = '{16'h1c40, 16'h1c20, 16'h1e12};
  localparam logic [15:0] stat_t [3] = '{`IRM_STAT_FIR, `IRM_STAT_SLOW, `IRM_STAT_SLOW};
  irm_setup u_dut (.REF_CLK(ref_clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(avs_rd), .AVS_WRITE(avs_wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
    .AVS_RESPONSE(resp), .IR_RXD(rxd), .IR_TXD(txd), .SPEED_SELECT_OUTPUT(spd), .RING_ACTIVE(ring_act),
    .RING_BASE(ring_base), .PHY_CLK_SEL(phy_sel), .LINK_CLK_EN(clk_en));
  irm_xcvr_model u_xcvr (.clk(ref_clk), .rst_n(nrst), .txd(txd), .rxd(rxd));
  // Makes the 200 MHz bus clock.
  always #2.5 ref_clk = ~ref_clk;
  // --------------------------------------------------------------------------
  // Tasks.
  // --------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge ref_clk);
    addr <= a;
    wdata <= {16'h0000, d};
    avs_wr <= w;
    avs_rd <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (wait_r === 1'b0) break;
    end
    q = rdata;
    r = resp;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (i == 20) begin
      n_errors++;
      $display("[FAIL] %0t bus timeout", $time);
      wrap_up();
    end
  endtask : bus
  // Compares one value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Lets registered outputs land, then looks off the edge.
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle
  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  // Resets, checks defaults, brings up each mode, then shuts down.
  initial begin
    {ref_clk, nrst, avs_rd, avs_wr, addr, wdata, n_errors, comparisons} = '0;
    be = 4'h3;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(0, `IRM_OFS_INTF_CFG, 16'h0000); chk(q, {16'h0000, `IRM_RST_INTF_CFG});
    bus(0, `IRM_OFS_MAX_PKT, 16'h0000); chk(q, 32'h0000_0020);
    for (m = 0; m < 3; m++) begin
      bus(1, `IRM_OFS_INTF_CFG, 16'h000c);
      bus(1, `IRM_OFS_ENABLE, 16'h0000);
      bus(1, `IRM_OFS_MAX_PKT, 16'h0020);
      bus(1, `IRM_OFS_PHY_CFG, phy_t[m]);
      bus(1, `IRM_OFS_PRI_CFG, pri_t[m]);
      bus(1, `IRM_OFS_RING_BASE_L, 16'h57ff);
      bus(1, `IRM_OFS_RING_BASE_H, 16'h1234);
      bus(1, `IRM_OFS_RING_SIZE, 16'h0040);
      bus(1, `IRM_OFS_SEC_CFG, 16'h0004);
      bus(0, `IRM_OFS_PHY_CFG, 16'h0000); chk(q, {16'h0000, phy_t[m]});
      bus(1, `IRM_OFS_ENABLE, 16'h8000);
      bus(0, `IRM_OFS_ENABLE, 16'h0000); chk(q, {16'h0000, stat_t[m]});
      settle();
      chk({31'h0, spd}, {31'h0, m != 2});
      chk({30'h0, phy_sel}, 32'h1);
      chk(ring_base, 32'h1234_5400);
      chk({31'h0, clk_en}, 32'h1);
      chk({31'h0, txd}, {31'h0, m == 2});
      bus(0, `IRM_OFS_RING_START, 16'h0000); chk(q, 32'h1);
      bus(1, `IRM_OFS_MAX_PKT, 16'h0033);
      bus(0, `IRM_OFS_MAX_PKT, 16'h0000); chk(q, 32'h0020);
      bus(1, `IRM_OFS_RING_START, 16'h0001); settle(); chk({31'h0, ring_act}, 32'h0);
      bus(1, `IRM_OFS_RING_START, 16'h0000); settle(); chk({31'h0, ring_act}, 32'h1);
      chk({31'h0, txd}, {31'h0, m == 2});
      bus(0, `IRM_OFS_RING_START, 16'h0000); chk(q, 32'h2);
    end
    bus(1, `IRM_OFS_ENABLE, 16'h0000); settle(); chk({31'h0, ring_act}, 32'h0);
    bus(0, `IRM_OFS_ENABLE, 16'h0000); chk(q, 32'h0);
    bus(1, `IRM_OFS_INTF_CFG, 16'h0008); settle(); chk({31'h0, clk_en}, 32'h0);
    // Second reset after shutdown: defaults come back and the ring stays idle.
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(0, `IRM_OFS_INTF_CFG, 16'h0000); chk(q, {16'h0000, `IRM_RST_INTF_CFG});
    bus(0, `IRM_OFS_RING_START, 16'h0000); chk(q, 32'h0);
    chk({31'h0, ring_act}, 32'h0);
    chk({31'h0, spd}, 32'h0);
    bus(0, 8'h40, 16'h0000); chk({30'h0, r}, 32'h2);
    wrap_up();
  end
endmodule : tb_top
